// file: bench/orient_assertions.sv
module orient_assertions
    import orient_pkg::*;
(
    input wire logic              I_CORE_CLK,
    input wire logic              I_RESET_N,
    input wire logic              I_PSEL,
    input wire logic              I_PENABLE,
    input wire logic [ADDR_W-1:0] I_PADDR,
    input wire logic              I_ORIENT_CMD,
    input wire logic              I_FWD_RUN,
    input wire logic [31:0]       O_PRDATA,
    input wire logic              O_PREADY,
    input wire logic              O_PSLVERR,
    input wire logic              O_ORIENT_COMPLETE,
    input wire logic              O_ORIENT_FAULT,
    input wire logic              O_DC_BRAKE,
    input wire logic              O_SERVO_TORQUE,
    input wire logic [15:0]       O_FREQ_CMD,
    input wire logic              O_ACCEL_TO_CMD
);
    // ****************************************************************
    // Checks on the pins.
    // ****************************************************************
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESET_N);
    ready_after_reset_a: assert property ($past(I_RESET_N, 2) |-> O_PREADY)
        else $error("Ready low outside reset.");
    unmapped_error_a: assert property (I_PSEL && !I_PENABLE && I_PADDR > 8'h1c
        |=> O_PSLVERR && O_PRDATA == 32'h0) else $error("Unmapped access not refused.");
    flags_idle_a: assert property (!I_ORIENT_CMD && !$past(I_ORIENT_CMD) &&
        !$past(I_ORIENT_CMD, 2) && !$past(I_ORIENT_CMD, 3)
        |-> !O_ORIENT_COMPLETE && !O_ORIENT_FAULT) else $error("Flag set while idle.");
    brake_servo_excl_a: assert property (!(O_DC_BRAKE && O_SERVO_TORQUE))
        else $error("Brake and servo torque together.");
    brake_freq_zero_a: assert property (O_DC_BRAKE |-> O_FREQ_CMD == 16'h0)
        else $error("Frequency output during DC brake.");
    abandon_accel_a: assert property (!I_ORIENT_CMD && !$past(I_ORIENT_CMD, 3) &&
        I_FWD_RUN && $past(I_FWD_RUN, 3) |-> O_ACCEL_TO_CMD) else $error("No acceleration.");
    flags_excl_a: assert property (!(O_ORIENT_COMPLETE && O_ORIENT_FAULT))
        else $error("Complete and fault together.");
    complete_cause_a: assert property ($rose(O_ORIENT_COMPLETE)
        |-> $past(I_ORIENT_CMD, 3)) else $error("Completion without command.");
endmodule
bind spindle_orientation_hold_control orient_assertions u_orient_assertions (
    .I_CORE_CLK, .I_RESET_N, .I_PSEL, .I_PENABLE, .I_PADDR, .I_ORIENT_CMD, .I_FWD_RUN,
    .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_ORIENT_COMPLETE, .O_ORIENT_FAULT, .O_DC_BRAKE,
    .O_SERVO_TORQUE, .O_FREQ_CMD, .O_ACCEL_TO_CMD
);

// file: bench/orient_motor_model.sv
module orient_motor_model (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [15:0] i_freq,
    input  wire logic        i_brake,
    input  wire logic        i_dir_rev,
    input  wire logic        i_push,
    output logic             o_a,
    output logic             o_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Shaft and encoder, one count every eight clocks.
    // ****************************************************************
    logic [1:0] phase;
    logic [2:0] div;
    // An outside push wins over the drive, as a real hand on the shaft would.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase <= 2'h0;
            div   <= 3'h0;
        end else begin
            div <= div + 3'h1;
            if (div == 3'h0 && i_push) begin
                phase <= phase + 2'h1;
            end else if (div == 3'h0 && i_freq != 16'h0 && !i_brake) begin
                phase <= i_dir_rev ? phase - 2'h1 : phase + 2'h1;
            end
        end
    end
    assign o_a = phase[0] ^ phase[1];
    assign o_b = phase[1];
endmodule

// file: bench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Harness. Reverse run stays off; only the forward path is exercised.
    // ****************************************************************
    logic clk, reset_n, psel, penable, pwrite, orient_cmd, fwd_run, push;
    logic pready, pslverr, complete, fault, brake, servo, dir_rev, accel, enc_a, enc_b;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] freq;
    int fails, checks_done, cycles;
    spindle_orientation_hold_control #(.TICK_CYCLES(10)) u_spindle_orientation_hold_control (
        .I_CORE_CLK(clk), .I_RESET_N(reset_n), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_ORIENT_CMD(orient_cmd),
        .I_FWD_RUN(fwd_run), .I_REV_RUN(1'b0), .I_ENC_A(enc_a), .I_ENC_B(enc_b),
        .O_ORIENT_COMPLETE(complete), .O_ORIENT_FAULT(fault), .O_DC_BRAKE(brake),
        .O_SERVO_TORQUE(servo), .O_FREQ_CMD(freq), .O_DIR_REV(dir_rev), .O_ACCEL_TO_CMD(accel));
    orient_motor_model u_orient_motor_model (.i_clk(clk), .i_reset_n(reset_n), .i_freq(freq),
        .i_brake(brake), .i_dir_rev(dir_rev), .i_push(push), .o_a(enc_a), .o_b(enc_b));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("Checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // The request is held until ready is seen at an edge; data is taken at that edge.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic orient(input logic [3:0] s, input logic hit);
        int n;
        apb(1'b1, 8'h00, {28'h0, s});
        apb(1'b0, 8'h1c, 32'h0);
        apb(1'b1, 8'h10, {16'h0, r[31:16]});
        orient_cmd <= 1'b1;
        fwd_run <= 1'b1;
        n = 0;
        while (complete !== 1'b1 && n < 3000) begin
            @(posedge clk);
            n++;
        end
        check("complete", complete, 1);
        if (hit) begin
            push <= 1'b1;
            repeat (96) @(posedge clk);
            push <= 0;
            repeat (16) @(posedge clk);
            check("kept", complete, 14'h3fe0 >> s & 1);
            check("fault", fault, 0);
            check("dc hold", brake, 14'h3fe1 >> s & 1);
            check("servo hold", servo, ~14'h3fe1 >> s & 1);
            check("servo drive", {freq != 0, dir_rev}, 3 * (~14'h3fe1 >> s & 1));
            orient_cmd <= 1'b0;
            repeat (4) @(posedge clk);
            check("accel", accel, 1);
            check("cleared", complete, 0);
            fwd_run <= 1'b0;
        end else begin
            fwd_run <= 1'b0;
            repeat (4) @(posedge clk);
            check("run off", complete, ~14'h01e7 >> s & 1);
            orient_cmd <= 1'b0;
            repeat (4) @(posedge clk);
            check("orient off", complete, 0);
        end
        repeat (4) @(posedge clk);
        $display("Test sel %0d hit %0d done", s, hit);
    endtask
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        static logic [15:0] rst_tab [7] = '{16'h0, 16'h32, 16'h1, 16'h1f4, 16'h0, 16'h5, 16'h5};
        {reset_n, psel, penable, pwrite, orient_cmd, fwd_run, push} = 7'h0;
        paddr = 8'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check("reset value", r, {16'h0, rst_tab[i]});
        end
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", {31'h0, pslverr}, 1);
        check("unmapped data", r, 0);
        apb(1'b1, 8'h00, 32'h0000000e);
        apb(1'b0, 8'h00, 32'h0);
        check("select kept", r[3:0], 0);
        apb(1'b0, 8'h1c, 32'h0);
        check("reject flag", r[4], 1);
        $display("Test registers done");
        apb(1'b1, 8'h0c, 32'h14);
        for (int s = 0; s < 14; s++) begin
            orient(4'(s), 1'b0);
            orient(4'(s), 1'b1);
        end
        complete_run();
    end
endmodule

// file: hdl/orient_pkg.sv
package orient_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 50_000_000;
    localparam int MS_PER_S        = 1000;
    localparam int CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
    localparam int COMPLETE_DELAY_MS = 500;
    localparam int STOP_CHECK_TICKS  = 2;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CREEP  = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_GAIN   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_DELAY  = 8'h0c;
    localparam logic [ADDR_W-1:0] ADDR_STOP   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_BRAKE  = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_ZONE   = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h1c;

    localparam int SEL_W      = 4;
    localparam int SEL_LSB    = 0;
    localparam int DIR_LSB    = 4;
    localparam int VEC_BIT    = 6;
    localparam int ST_CMPL    = 0;
    localparam int ST_FAULT   = 1;
    localparam int ST_ATT_LSB = 2;
    localparam int ST_REJECT  = 4;
    localparam int ST_BRAKE   = 5;
    localparam int ST_SERVO   = 6;
    localparam int ST_POS_LSB = 16;

    localparam logic [SEL_W-1:0] SEL_RST    = 4'h0;
    localparam logic [SEL_W-1:0] SEL_MAX    = 4'hd;
    localparam logic [1:0]       DIR_RST    = 2'h0;
    localparam logic [15:0]      CREEP_RST  = 16'h0032;
    localparam logic [15:0]      GAIN_RST   = 16'h0001;
    localparam logic [15:0]      DELAY_RST  = 16'h01f4;
    localparam logic [15:0]      STOP_RST   = 16'h0000;
    localparam logic [15:0]      BRAKE_RST  = 16'h0005;
    localparam logic [15:0]      ZONE_RST   = 16'h0005;
    localparam logic [1:0]       ATTEMPT_MAX = 2'h3;

    // ****************************************************************
    // Behaviour per selection value, bit n for value n
    // ****************************************************************
    localparam logic [13:0] SERVO_MASK  = 14'h255e;
    localparam logic [13:0] RETRY_MASK  = 14'h0880;
    localparam logic [13:0] COMP_MASK   = 14'h306c;
    localparam logic [13:0] DCHOLD_MASK = 14'h3fe1;
    localparam logic [13:0] RUNCLR_MASK = 14'h01e7;
    localparam logic [13:0] EXITCLR_MASK = 14'h001f;

    localparam logic [1:0] DIR_CURRENT = 2'h0;
    localparam logic [1:0] DIR_FWD     = 2'h1;
    localparam logic [1:0] DIR_REV     = 2'h2;

    typedef enum logic [3:0] {
        S_IDLE, S_TURN, S_APPROACH, S_BRAKE, S_COMP, S_SETTLE, S_DONE, S_FAULT
    } state_t;

endpackage

// file: hdl/quad_position_counter.sv
module quad_position_counter
    import orient_pkg::*;
#(
    parameter int W = 16
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic         i_a,
    input  wire logic         i_b,
    output logic [W-1:0]      o_pos
);

    logic [1:0] prev;
    logic [1:0] cur;

    assign cur = {i_a, i_b};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev <= 2'h0;
            o_pos <= '0;
        end else begin
            prev <= cur;
            // Gray sequence 00-10-11-01 counts up, the reverse counts down.
            case ({prev, cur})
                4'h2, 4'hb, 4'hd, 4'h4: o_pos <= o_pos + W'(1);
                4'h1, 4'h7, 4'he, 4'h8: o_pos <= o_pos - W'(1);
                default: o_pos <= o_pos;
            endcase
        end
    end

endmodule

// file: hdl/spindle_orientation_hold_control.sv
// Functional notes
// - Servo hold before completion only for selections 1,2,3,4,6,8,10,13.
// - No servo torque while position is inside the brake start width.
// - Hold by DC brake; servo torque pulls shaft back when outside width.
// - Retry enabled only for selections 7 and 11.
// - Retry and servo hold are never enabled together.
// - With retry, a stop outside the zone restarts orientation.
// - At most three attempts, the first one included.
// - Fault flag held off while a retry is running.
// - Selections 2,3,5,6,12,13 raise frequency when stopped short of zone.
// - Compensation ramps frequency up gradually, capped at creep speed.
// - Compensation and retry are never enabled together.
// - After completion, leaving zone: DC brake for 0,5-13, servo for 1-4.
// - Completion clears on run or orient off (0,1,2,5-8), else orient only.
// - Leaving zone after completion clears flag for 0-4, keeps it for 5-13.
// - Orient off with run on abandons orientation, accelerates to command.
// - Servo torque frequency ramps to creep speed at position loop gain slope.
// - Vector mode direction: current, forward or reverse, turning first.
// - Completion after resting in zone for the completion delay.
// - Completion and fault flags stay off while orient command is off.
//
// The APB slave port and the address map are this design's own decisions.
module spindle_orientation_hold_control
    import orient_pkg::*;
#(
    parameter int TICK_CYCLES = CYCLES_PER_MS,
    parameter int POS_W       = 16
) (
    input  wire logic              I_CORE_CLK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]       I_PWDATA,
    output logic [31:0]            O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    input  wire logic              I_ORIENT_CMD,
    input  wire logic              I_FWD_RUN,
    input  wire logic              I_REV_RUN,
    input  wire logic              I_ENC_A,
    input  wire logic              I_ENC_B,
    output logic                   O_ORIENT_COMPLETE,
    output logic                   O_ORIENT_FAULT,
    output logic                   O_DC_BRAKE,
    output logic                   O_SERVO_TORQUE,
    output logic [15:0]            O_FREQ_CMD,
    output logic                   O_DIR_REV,
    output logic                   O_ACCEL_TO_CMD
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [4:0] sync1;
    logic [4:0] sync2;

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end else begin
            sync1 <= {I_ENC_B, I_ENC_A, I_REV_RUN, I_FWD_RUN, I_ORIENT_CMD};
            sync2 <= sync1;
        end
    end

    logic orient_on;
    logic fwd_on;
    logic rev_on;
    logic run_on;
    logic run_prev;
    logic run_fell;

    assign orient_on = sync2[0];
    assign fwd_on    = sync2[1];
    assign rev_on    = sync2[2];
    assign run_on    = fwd_on | rev_on;
    assign run_fell  = run_prev & ~run_on;

    logic [POS_W-1:0] pos;

    quad_position_counter #(.W(POS_W)) u_counter (
        .i_clk     (I_CORE_CLK),
        .i_reset_n (I_RESET_N),
        .i_a       (sync2[3]),
        .i_b       (sync2[4]),
        .o_pos     (pos)
    );

    // ****************************************************************
    // Settings registers and APB slave
    // ****************************************************************
    logic [SEL_W-1:0] sel;
    logic [1:0]       dir_set;
    logic             vec_mode;
    logic [15:0]      creep;
    logic [15:0]      gain;
    logic [15:0]      delay_ms;
    logic [15:0]      stop_pos;
    logic [15:0]      brake_w;
    logic [15:0]      zone_w;
    logic             reject;
    logic [1:0]       attempts;
    state_t           state;

    logic wr;
    logic setup;
    logic [SEL_W-1:0] wr_sel;

    assign wr     = I_PSEL & I_PENABLE & I_PWRITE;
    assign setup  = I_PSEL & ~I_PENABLE;
    assign wr_sel = I_PWDATA[SEL_LSB +: SEL_W];

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sel      <= SEL_RST;
            dir_set  <= DIR_RST;
            vec_mode <= 1'b0;
            creep    <= CREEP_RST;
            gain     <= GAIN_RST;
            delay_ms <= DELAY_RST;
            stop_pos <= STOP_RST;
            brake_w  <= BRAKE_RST;
            zone_w   <= ZONE_RST;
            reject   <= 1'b0;
        end else if (wr) begin
            if (I_PADDR == ADDR_CTRL) begin
                // An undefined selection keeps the old one and flags the attempt.
                if (wr_sel > SEL_MAX) begin
                    reject <= 1'b1;
                end else begin
                    sel <= wr_sel;
                end
                dir_set  <= I_PWDATA[DIR_LSB +: 2];
                vec_mode <= I_PWDATA[VEC_BIT];
            end else if (I_PADDR == ADDR_CREEP) begin
                creep <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_GAIN) begin
                gain <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_DELAY) begin
                delay_ms <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_STOP) begin
                stop_pos <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_BRAKE) begin
                brake_w <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_ZONE) begin
                zone_w <= I_PWDATA[15:0];
            end else if (I_PADDR == ADDR_STATUS) begin
                if (I_PWDATA[ST_REJECT]) begin
                    reject <= 1'b0;
                end
            end
        end
    end

    logic [31:0] status;

    always_comb begin
        status = 32'h0000_0000;
        status[ST_CMPL]             = O_ORIENT_COMPLETE;
        status[ST_FAULT]            = O_ORIENT_FAULT;
        status[ST_ATT_LSB +: 2]     = attempts;
        status[ST_REJECT]           = reject;
        status[ST_BRAKE]            = O_DC_BRAKE;
        status[ST_SERVO]            = O_SERVO_TORQUE;
        status[ST_POS_LSB +: POS_W] = pos;
    end

    // Read data is sampled in the setup cycle so the access phase ends at once.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
            O_PREADY  <= 1'b0;
        end else begin
            O_PREADY <= 1'b1;
            if (setup) begin
                O_PSLVERR <= 1'b0;
                O_PRDATA  <= 32'h0000_0000;
                if (I_PADDR == ADDR_CTRL) begin
                    O_PRDATA <= {25'h0, vec_mode, dir_set, sel};
                end else if (I_PADDR == ADDR_CREEP) begin
                    O_PRDATA <= {16'h0, creep};
                end else if (I_PADDR == ADDR_GAIN) begin
                    O_PRDATA <= {16'h0, gain};
                end else if (I_PADDR == ADDR_DELAY) begin
                    O_PRDATA <= {16'h0, delay_ms};
                end else if (I_PADDR == ADDR_STOP) begin
                    O_PRDATA <= {16'h0, stop_pos};
                end else if (I_PADDR == ADDR_BRAKE) begin
                    O_PRDATA <= {16'h0, brake_w};
                end else if (I_PADDR == ADDR_ZONE) begin
                    O_PRDATA <= {16'h0, zone_w};
                end else if (I_PADDR == ADDR_STATUS) begin
                    O_PRDATA <= status;
                end else begin
                    O_PSLVERR <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Behaviour decode and position terms
    // ****************************************************************
    logic servo_en;
    logic retry_en;
    logic comp_en;
    logic dc_hold;
    logic clr_on_run;
    logic clr_on_exit;

    assign servo_en    = SERVO_MASK[sel];
    // Masking retry against the other two keeps it exclusive; servo hold and compensation can both be enabled.
    assign retry_en    = RETRY_MASK[sel] & ~SERVO_MASK[sel] & ~COMP_MASK[sel];
    assign comp_en     = COMP_MASK[sel] & ~RETRY_MASK[sel];
    assign dc_hold     = DCHOLD_MASK[sel];
    assign clr_on_run  = RUNCLR_MASK[sel];
    assign clr_on_exit = EXITCLR_MASK[sel];

    logic [15:0] err;
    logic [15:0] abs_err;
    logic        in_brake;
    logic        in_zone;

    assign err      = stop_pos - pos;
    assign abs_err  = err[15] ? 16'(-err) : err;
    assign in_brake = abs_err <= brake_w;
    assign in_zone  = abs_err <= zone_w;

    // One tick per millisecond paces ramps, stop checks and the delay.
    logic [31:0] tick_cnt;
    logic        tick;

    assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
        end
    end

    logic [POS_W-1:0] last_pos;
    logic [1:0]       still_ticks;
    logic             stopped;

    assign stopped = still_ticks == 2'(STOP_CHECK_TICKS);

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            last_pos    <= '0;
            still_ticks <= 2'h0;
            run_prev    <= 1'b0;
        end else begin
            run_prev <= run_on;
            if (tick) begin
                last_pos <= pos;
                if (pos != last_pos) begin
                    still_ticks <= 2'h0;
                end else if (!stopped) begin
                    still_ticks <= still_ticks + 2'h1;
                end
            end
        end
    end

    logic [15:0] ramp_up;
    logic [15:0] ramp_dn;
    logic [16:0] sum;

    assign sum     = {1'b0, O_FREQ_CMD} + {1'b0, gain};
    assign ramp_up = (sum > {1'b0, creep}) ? creep : sum[15:0];
    assign ramp_dn = (O_FREQ_CMD > gain) ? 16'(O_FREQ_CMD - gain) : 16'h0;

    logic target_rev;

    always_comb begin
        target_rev = rev_on;
        if (vec_mode && dir_set == DIR_FWD) begin
            target_rev = 1'b0;
        end else if (vec_mode && dir_set == DIR_REV) begin
            target_rev = 1'b1;
        end
    end

    // ****************************************************************
    // Orientation sequence
    // ****************************************************************
    logic [15:0] settle_ms;

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state             <= S_IDLE;
            attempts          <= 2'h0;
            settle_ms         <= 16'h0;
            O_ORIENT_COMPLETE <= 1'b0;
            O_ORIENT_FAULT    <= 1'b0;
            O_DC_BRAKE        <= 1'b0;
            O_SERVO_TORQUE    <= 1'b0;
            O_FREQ_CMD        <= 16'h0;
            O_DIR_REV         <= 1'b0;
            O_ACCEL_TO_CMD    <= 1'b0;
        end else if (!orient_on) begin
            state             <= S_IDLE;
            attempts          <= 2'h0;
            O_ORIENT_COMPLETE <= 1'b0;
            O_ORIENT_FAULT    <= 1'b0;
            O_DC_BRAKE        <= 1'b0;
            O_SERVO_TORQUE    <= 1'b0;
            O_FREQ_CMD        <= 16'h0;
            O_ACCEL_TO_CMD    <= run_on;
        end else begin
            O_ACCEL_TO_CMD <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (run_on) begin
                        attempts <= 2'h1;
                        if (vec_mode && dir_set != DIR_CURRENT && target_rev != rev_on) begin
                            O_FREQ_CMD <= creep;
                            O_DIR_REV  <= rev_on;
                            state      <= S_TURN;
                        end else begin
                            O_DIR_REV <= target_rev;
                            state     <= S_APPROACH;
                        end
                    end
                end
                S_TURN: begin
                    if (O_FREQ_CMD == 16'h0) begin
                        O_DIR_REV <= target_rev;
                        state     <= S_APPROACH;
                    end else if (tick) begin
                        O_FREQ_CMD <= ramp_dn;
                    end
                end
                S_APPROACH: begin
                    O_DC_BRAKE <= 1'b0;
                    if (in_brake) begin
                        O_FREQ_CMD <= 16'h0;
                        state      <= S_BRAKE;
                    end else if (tick) begin
                        O_FREQ_CMD <= ramp_up;
                    end
                end
                S_BRAKE: begin
                    if (servo_en && !in_brake) begin
                        O_DC_BRAKE     <= 1'b0;
                        O_SERVO_TORQUE <= 1'b1;
                        O_DIR_REV      <= err[15];
                        if (tick) begin
                            O_FREQ_CMD <= ramp_up;
                        end
                    end else begin
                        O_DC_BRAKE     <= 1'b1;
                        O_SERVO_TORQUE <= 1'b0;
                        O_FREQ_CMD     <= 16'h0;
                    end
                    if (stopped && in_zone) begin
                        settle_ms <= 16'h0;
                        state     <= S_SETTLE;
                    end else if (stopped && retry_en && attempts < ATTEMPT_MAX) begin
                        attempts   <= attempts + 2'h1;
                        O_DC_BRAKE <= 1'b0;
                        state      <= S_APPROACH;
                    end else if (stopped && comp_en && !in_brake) begin
                        O_DC_BRAKE <= 1'b0;
                        state      <= S_COMP;
                    end else if (stopped && !servo_en && !comp_en) begin
                        O_ORIENT_FAULT <= 1'b1;
                        state          <= S_FAULT;
                    end
                end
                S_COMP: begin
                    if (in_brake) begin
                        O_FREQ_CMD <= 16'h0;
                        state      <= S_BRAKE;
                    end else if (tick) begin
                        O_FREQ_CMD <= ramp_up;
                    end
                end
                S_SETTLE: begin
                    if (!in_zone) begin
                        state <= S_BRAKE;
                    end else if (settle_ms >= delay_ms) begin
                        O_ORIENT_COMPLETE <= 1'b1;
                        state             <= S_DONE;
                    end else if (tick) begin
                        settle_ms <= settle_ms + 16'h1;
                    end
                end
                S_DONE: begin
                    // Run may drop while orient stays on; the hold continues.
                    if (run_fell && clr_on_run) begin
                        O_ORIENT_COMPLETE <= 1'b0;
                    end
                    if (!in_zone) begin
                        O_DC_BRAKE     <= dc_hold;
                        O_SERVO_TORQUE <= ~dc_hold;
                        if (!dc_hold && tick) begin
                            O_FREQ_CMD <= ramp_up;
                        end
                        if (clr_on_exit) begin
                            O_ORIENT_COMPLETE <= 1'b0;
                            state             <= S_BRAKE;
                        end
                    end else begin
                        O_DC_BRAKE     <= 1'b1;
                        O_SERVO_TORQUE <= 1'b0;
                        O_FREQ_CMD     <= 16'h0;
                    end
                end
                S_FAULT: begin
                    O_ORIENT_FAULT <= 1'b1;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

endmodule
